// ### uaoc_top.sv
// Purpose: usb audio output control: pipes, speaker bank fill, volume, converter
// Assumes: avalon-mm slave, byte address, 8-bit registers in the low byte lane
// Notes:   every access takes two wait cycles; unmapped reads return zero
// Operation
// - toggle restart bit forces next packets DATA0
// - bit 1 sets ep1 direction, reset input
// - bit 2 sets ep2 direction, reset output
// - wrong-direction tokens ignored, endpoint stays enabled
// - load start begins copying audio into banks
// - bank full flag set when fill completes
// - layout 0: 512 averaged samples fill banks
// - layout 1: 256 left, 256 right samples
// - seven-bit gain code, +6 to -22 dB
// - mute bit low silences the speaker
// - bound bytes clamp host data to converter
// - literal mode: trigger fall loads bound bytes
// - trigger register reads zero except bit 3
// - disabled endpoint blocks its access port
`timescale 1ns/1ps
module uaoc_top
	import uaoc_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        iso_valid_i,
	input  wire logic [15:0] iso_left_i,
	input  wire logic [15:0] iso_right_i,
	output logic             iso_ready_o,
	input  wire logic        tok_valid_i,
	input  wire logic [1:0]  tok_ep_i,
	input  wire logic        tok_in_i,
	output logic             tok_accept_o,
	input  wire logic [2:0]  pkt_done_i,
	output logic      [2:0]  pid_data1_o,
	output logic             data0_restart_o,
	output logic             ep1_dir_o,
	output logic             ep2_dir_o,
	input  wire logic [2:0]  ep_enable_i,
	input  wire logic [7:0]  ep_rdata_i,
	output logic      [1:0]  ep_sel_o,
	output logic             ep_rd_o,
	output logic             ep_wr_o,
	output logic      [7:0]  ep_wdata_o,
	output logic      [15:0] dac_l_code_o,
	output logic      [15:0] dac_r_code_o,
	output logic      [6:0]  pga_code_o,
	output logic             mute_o,
	output logic             irq_o
);
	typedef struct packed {
		uaoc_fill_st_t     st;
		logic [8:0]        cnt;
		logic              lr;
		logic [7:0]        rbyte;
		logic [1:0]        ph;
		logic [31:0]       rdata;
		logic [7:0]        ctl;
		logic [7:0]        dir;
		logic [7:0]        gain;
		logic [7:0]        blo;
		logic [7:0]        bhi;
		logic [7:0]        trig;
		logic [7:0]        wdt;
		logic [IRQ_W-1:0]  stat;
		logic [IRQ_W-1:0]  mask;
		logic [2:0]        pid1;
		logic              restart;
		logic [1:0]        ep_sel;
		logic [7:0]        ep_wdata;
	} uaoc_state_t;

	localparam logic [1:0] PH_IDLE = 2'd0;
	localparam logic [1:0] PH_READ = 2'd1;
	localparam logic [1:0] PH_DONE = 2'd2;

	uaoc_state_t s_r;
	uaoc_state_t s_nxt;

	logic [9:0]        idx;
	logic              req;
	logic              ph_done;
	logic              wr_go;
	logic [7:0]        wd;
	logic              is_ram;
	logic              is_ep;
	logic [1:0]        ep_n;
	logic              ep_ok;
	logic [8:0]        ram_raddr;
	logic [7:0]        ram_rdata;
	logic              ram_we;
	logic [8:0]        ram_waddr;
	logic [7:0]        ram_wdata;
	logic              iso_take;
	logic [16:0]       mix_sum;
	logic [15:0]       mix;
	logic              fill_done;
	logic              literal_mode;
	logic              literal_load;
	logic [IRQ_W-1:0]  ev;
	logic [15:0]       bound;
	logic [1:0][15:0]  dac_w;
	logic [1:0][6:0]   pga_w;
	logic [1:0]        mute_w;
	logic [1:0][15:0]  smp_w;

	function automatic logic [7:0] trunc8(input logic [15:0] s);
		trunc8 = {s[15], s[13:7]};
	endfunction

	assign idx       = avs_address_i[11:2];
	assign req       = avs_read_i | avs_write_i;
	assign ph_done   = req && s_r.ph == PH_DONE;
	assign wr_go     = avs_write_i && ph_done;
	assign wd        = avs_writedata_i[7:0];
	assign is_ram    = idx >= IDX_RAM_BASE && idx < IDX_RAM_END;
	assign is_ep     = idx >= IDX_EP0 && idx <= IDX_EP2;
	assign ep_n      = 2'(idx - IDX_EP0);
	assign ram_raddr = 9'(idx - IDX_RAM_BASE);
	assign ep_ok     = s_r.ep_sel <= 2'd2 && ep_enable_i[s_r.ep_sel];
	assign bound     = {s_r.bhi, s_r.blo};
	assign literal_mode = s_r.wdt[7:4] == WDT_LITERAL;
	// fall of the trigger bit, seen as a write clearing a set bit
	assign literal_load = wr_go && idx == IDX_TRIG && s_r.trig[BIT_TRIG] &&
		!wd[BIT_TRIG] && literal_mode;

	// the second half of a left/right pair stalls the stream for one cycle
	assign iso_ready_o = s_r.st != ST_SECOND;
	assign iso_take    = iso_valid_i && iso_ready_o;
	assign mix_sum     = {iso_left_i[15], iso_left_i} + {iso_right_i[15], iso_right_i};
	assign mix         = mix_sum[16:1];

	// bank fill writes
	always_comb begin
		ram_we = 1'b0;
		ram_waddr = s_r.cnt;
		ram_wdata = trunc8(mix);
		fill_done = 1'b0;
		if (s_r.st == ST_TAKE && iso_take) begin
			ram_we = 1'b1;
			if (s_r.lr) begin
				ram_wdata = trunc8(iso_left_i);
			end else begin
				fill_done = s_r.cnt == MIX_LAST;
			end
		end else if (s_r.st == ST_SECOND) begin
			ram_we = 1'b1;
			ram_waddr = RIGHT_BASE | s_r.cnt;
			ram_wdata = s_r.rbyte;
			fill_done = s_r.cnt == LR_LAST;
		end
	end

	// wrong-direction tokens are dropped here so the pipe is never halted
	always_comb begin
		unique case (tok_ep_i)
			2'd1: tok_accept_o = tok_valid_i && tok_in_i == s_r.dir[BIT_EP1DIR];
			2'd2: tok_accept_o = tok_valid_i && tok_in_i == s_r.dir[BIT_EP2DIR];
			default: tok_accept_o = tok_valid_i;
		endcase
	end

	always_comb begin
		ev = '0;
		ev[IRQ_FILLED]  = fill_done;
		ev[IRQ_BADTOK]  = tok_valid_i && !tok_accept_o;
		ev[IRQ_LITERAL] = literal_load;
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.restart = 1'b0;
		s_nxt.pid1 = s_r.pid1 ^ pkt_done_i;
		// bus phases: see request, capture read data, finish
		unique case (s_r.ph)
			PH_IDLE: begin
				if (req) begin
					s_nxt.ph = PH_READ;
				end
			end
			PH_READ: begin
				s_nxt.ph = PH_DONE;
				s_nxt.ep_sel = ep_n;
				s_nxt.ep_wdata = wd;
				s_nxt.rdata = '0;
				if (is_ram) begin
					s_nxt.rdata[7:0] = ram_rdata;
				end else if (is_ep) begin
					s_nxt.rdata[7:0] = ep_enable_i[ep_n] ? ep_rdata_i : 8'h00;
				end else begin
					unique case (idx)
						IDX_WDT:      s_nxt.rdata[7:0] = s_r.wdt;
						IDX_BANK_CTL: s_nxt.rdata[7:0] = s_r.ctl;
						IDX_GAIN:     s_nxt.rdata[7:0] = s_r.gain;
						IDX_DIR:      s_nxt.rdata[7:0] = s_r.dir;
						IDX_BOUND_LO: s_nxt.rdata[7:0] = s_r.blo;
						IDX_BOUND_HI: s_nxt.rdata[7:0] = s_r.bhi;
						IDX_TRIG:     s_nxt.rdata[7:0] = s_r.trig & MASK_TRIG;
						IDX_IRQ_STAT: s_nxt.rdata[IRQ_W-1:0] = s_r.stat;
						IDX_IRQ_MASK: s_nxt.rdata[IRQ_W-1:0] = s_r.mask;
						default:      s_nxt.rdata = '0;
					endcase
				end
			end
			default: begin
				s_nxt.ph = PH_IDLE;
			end
		endcase

		if (wr_go) begin
			unique case (idx)
				IDX_WDT:      s_nxt.wdt = wd;
				IDX_GAIN:     s_nxt.gain = wd;
				IDX_BOUND_LO: s_nxt.blo = wd;
				IDX_BOUND_HI: s_nxt.bhi = wd;
				IDX_TRIG:     s_nxt.trig = wd & MASK_TRIG;
				IDX_IRQ_MASK: s_nxt.mask = wd[IRQ_W-1:0];
				IDX_DIR: begin
					s_nxt.dir = wd & MASK_DIR;
					if (wd[BIT_TOGGLE] != s_r.dir[BIT_TOGGLE]) begin
						s_nxt.restart = 1'b1;
						s_nxt.pid1 = '0;
					end
				end
				IDX_BANK_CTL: begin
					s_nxt.ctl[BIT_LAYOUT] = wd[BIT_LAYOUT];
					if (!wd[BIT_FULL]) begin
						s_nxt.ctl[BIT_FULL] = 1'b0;
					end
					if (wd[BIT_START] && s_r.st == ST_IDLE) begin
						s_nxt.ctl[BIT_START] = 1'b1;
						s_nxt.st = ST_TAKE;
						s_nxt.cnt = '0;
						s_nxt.lr = wd[BIT_LAYOUT];
					end
				end
				default: begin
				end
			endcase
		end

		// fill engine; completion after the bus write so the set wins
		unique case (s_r.st)
			ST_IDLE: begin
			end
			ST_TAKE: begin
				if (iso_take) begin
					if (s_r.lr) begin
						s_nxt.rbyte = trunc8(iso_right_i);
						s_nxt.st = ST_SECOND;
					end else begin
						s_nxt.cnt = s_r.cnt + 9'd1;
					end
				end
			end
			ST_SECOND: begin
				s_nxt.cnt = s_r.cnt + 9'd1;
				s_nxt.st = ST_TAKE;
			end
		endcase
		if (fill_done) begin
			s_nxt.st = ST_IDLE;
			s_nxt.ctl[BIT_START] = 1'b0;
			s_nxt.ctl[BIT_FULL] = 1'b1;
		end

		// sticky status, write one to clear, a new event wins
		if (wr_go && idx == IDX_IRQ_STAT) begin
			s_nxt.stat = s_r.stat & ~wd[IRQ_W-1:0];
		end
		s_nxt.stat = s_nxt.stat | ev;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s_r <= '{st: ST_IDLE, dir: RST_DIR, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	uaoc_bank_ram u_ram (
		.core_clk_i (core_clk_i),
		.we_i       (ram_we),
		.waddr_i    (ram_waddr),
		.wdata_i    (ram_wdata),
		.raddr_i    (ram_raddr),
		.rdata_o    (ram_rdata)
	);

	assign smp_w[0] = iso_left_i;
	assign smp_w[1] = iso_right_i;

	// channel 0 is left, channel 1 is right
	for (genvar c = 0; c < 2; c++) begin : g_chan
		uaoc_dac_path u_dac (
			.core_clk_i     (core_clk_i),
			.rst_i          (rst_i),
			.smp_valid_i    (iso_take),
			.smp_i          (smp_w[c]),
			.bound_i        (bound),
			.literal_mode_i (literal_mode),
			.literal_load_i (literal_load),
			.gain_mute_i    (s_r.gain),
			.dac_code_o     (dac_w[c]),
			.pga_code_o     (pga_w[c]),
			.mute_o         (mute_w[c])
		);
	end

	assign avs_waitrequest_o = req && !ph_done;
	assign avs_readdata_o    = s_r.rdata;
	assign pid_data1_o       = s_r.pid1;
	assign data0_restart_o   = s_r.restart;
	assign ep1_dir_o         = s_r.dir[BIT_EP1DIR];
	assign ep2_dir_o         = s_r.dir[BIT_EP2DIR];
	assign ep_sel_o          = s_r.ep_sel;
	assign ep_wdata_o        = s_r.ep_wdata;
	// access strobes only reach an enabled endpoint
	assign ep_rd_o           = avs_read_i && ph_done && is_ep && ep_ok;
	assign ep_wr_o           = wr_go && is_ep && ep_ok;
	assign dac_l_code_o      = dac_w[0];
	assign dac_r_code_o      = dac_w[1];
	assign pga_code_o        = pga_w[0];
	assign mute_o            = mute_w[0];
	assign irq_o             = |(s_r.stat & s_r.mask);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_restart_pid: assert property (data0_restart_o |-> pid_data1_o == 3'b000)
		else $error("restart did not clear data toggles");
	a_ep1_dir_reset: assert property ($fell(rst_i) |-> ep1_dir_o && !ep2_dir_o)
		else $error("direction reset value wrong");
	a_ep2_dir_write: assert property (wr_go && idx == IDX_DIR |=>
		ep2_dir_o == $past(wd[BIT_EP2DIR])) else $error("ep2 direction not stored");
	a_token_filter: assert property (tok_valid_i && tok_ep_i == 2'd1 &&
		tok_in_i != ep1_dir_o |-> !tok_accept_o) else $error("bad token accepted");
	a_fill_start: assert property (wr_go && idx == IDX_BANK_CTL && wd[BIT_START] &&
		s_r.st == ST_IDLE |=> s_r.st == ST_TAKE && s_r.cnt == 9'd0) else $error("no fill");
	a_full_set: assert property (fill_done |=> s_r.ctl[BIT_FULL] &&
		s_r.st == ST_IDLE && (irq_o || !s_r.mask[IRQ_FILLED])) else $error("full not set");
	a_mix_byte: assert property (ram_we && !s_r.lr |-> ram_wdata ==
		trunc8(16'(17'($signed(iso_left_i) + $signed(iso_right_i)) >>> 1))) else $error("mix");
	a_lr_split: assert property (ram_we && s_r.lr |-> ram_waddr[8] ==
		(s_r.st == ST_SECOND) && ram_waddr[7:0] == s_r.cnt[7:0]) else $error("lr address");
	a_trig_zero: assert property (avs_read_i && ph_done && idx == IDX_TRIG |->
		(avs_readdata_o & ~32'h0000_0008) == 32'h0) else $error("trigger bits not zero");
	a_ep_gate: assert property (ep_rd_o || ep_wr_o |-> ep_enable_i[ep_sel_o])
		else $error("disabled endpoint accessed");
	a_full_clear: assert property (wr_go && idx == IDX_BANK_CTL && !wd[BIT_FULL] &&
		!fill_done |=> !s_r.ctl[BIT_FULL]) else $error("full not cleared");
endmodule

// ### uaoc_pkg.sv
// Purpose: shared constants and types for the usb audio output control block
// Assumes: register indices are word indices, byte address is four times the index
// Notes:   all registers are 8 bits wide in the low byte of the 32-bit bus word
package uaoc_pkg;
	localparam logic [9:0] IDX_WDT       = 10'h009;
	localparam logic [9:0] IDX_BANK_CTL  = 10'h01d;
	localparam logic [9:0] IDX_GAIN      = 10'h01e;
	localparam logic [9:0] IDX_EP0       = 10'h020;
	localparam logic [9:0] IDX_EP2       = 10'h022;
	localparam logic [9:0] IDX_DIR       = 10'h027;
	localparam logic [9:0] IDX_BOUND_LO  = 10'h02d;
	localparam logic [9:0] IDX_BOUND_HI  = 10'h02e;
	localparam logic [9:0] IDX_TRIG      = 10'h02f;
	localparam logic [9:0] IDX_IRQ_STAT  = 10'h030;
	localparam logic [9:0] IDX_IRQ_MASK  = 10'h031;
	localparam logic [9:0] IDX_RAM_BASE  = 10'h100;
	localparam logic [9:0] IDX_RAM_END   = 10'h300;

	localparam int BIT_TOGGLE = 0;
	localparam int BIT_EP1DIR = 1;
	localparam int BIT_EP2DIR = 2;
	localparam int BIT_START  = 0;
	localparam int BIT_FULL   = 1;
	localparam int BIT_LAYOUT = 2;
	localparam int BIT_MUTE_N = 7;
	localparam int BIT_TRIG   = 3;

	localparam logic [7:0] RST_DIR    = 8'h02;
	localparam logic [7:0] MASK_DIR   = 8'h07;
	localparam logic [7:0] MASK_CTL   = 8'h07;
	localparam logic [7:0] MASK_TRIG  = 8'h08;
	localparam logic [3:0] WDT_LITERAL = 4'h5;

	localparam logic [8:0] MIX_LAST   = 9'h1ff;
	localparam logic [8:0] LR_LAST    = 9'h0ff;
	localparam logic [8:0] RIGHT_BASE = 9'h100;

	localparam logic [6:0]  VOL_MAX = 7'h0c;
	localparam logic [6:0]  VOL_MIN = 7'h54;
	localparam logic [15:0] DAC_MID = 16'h8000;

	localparam int IRQ_FILLED  = 0;
	localparam int IRQ_BADTOK  = 1;
	localparam int IRQ_LITERAL = 2;
	localparam int IRQ_W       = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_TAKE, ST_SECOND} uaoc_fill_st_t;
endpackage

// ### uaoc_bank_ram.sv
// Purpose: four 128-byte speaker banks as one 512-byte store
// Assumes: one write port for the fill engine, one read port for software
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/1ps
module uaoc_bank_ram
	import uaoc_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       we_i,
	input  wire logic [8:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [8:0] raddr_i,
	output logic      [7:0] rdata_o
);
	typedef struct packed {
		logic [511:0][7:0] mem;
		logic [7:0]        q;
	} uaoc_ram_t;

	uaoc_ram_t s_r;
	uaoc_ram_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.q = s_r.mem[raddr_i];
		if (we_i) begin
			s_nxt.mem[waddr_i] = wdata_i;
		end
	end

	// no reset: bank contents are undefined until the first fill
	always_ff @(posedge core_clk_i) begin
		s_r <= s_nxt;
	end

	assign rdata_o = s_r.q;
endmodule

// ### uaoc_dac_path.sv
// Purpose: one converter channel: clamp, mute, literal load and gain code
// Assumes: samples are two's complement, converter code is offset binary
// Notes:   the literal load beats the stream in the same cycle
`timescale 1ns/1ps
module uaoc_dac_path
	import uaoc_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        smp_valid_i,
	input  wire logic [15:0] smp_i,
	input  wire logic [15:0] bound_i,
	input  wire logic        literal_mode_i,
	input  wire logic        literal_load_i,
	input  wire logic [7:0]  gain_mute_i,
	output logic      [15:0] dac_code_o,
	output logic      [6:0]  pga_code_o,
	output logic             mute_o
);
	typedef struct packed {
		logic [15:0] dac;
		logic [6:0]  pga;
		logic        mute;
	} uaoc_dac_t;

	uaoc_dac_t s_r;
	uaoc_dac_t s_nxt;
	logic [15:0] ucode;
	logic [6:0]  vol;

	always_comb begin
		s_nxt = s_r;
		ucode = {~smp_i[15], smp_i[14:0]};
		vol = gain_mute_i[6:0];
		// codes outside the table saturate to its ends
		if ($signed(vol) > $signed(VOL_MAX)) begin
			vol = VOL_MAX;
		end else if ($signed(vol) < $signed(VOL_MIN)) begin
			vol = VOL_MIN;
		end
		s_nxt.pga = vol;
		s_nxt.mute = ~gain_mute_i[BIT_MUTE_N];
		if (literal_load_i) begin
			s_nxt.dac = bound_i;
		end else if (!literal_mode_i) begin
			if (!gain_mute_i[BIT_MUTE_N]) begin
				s_nxt.dac = DAC_MID;
			end else if (smp_valid_i) begin
				s_nxt.dac = (ucode > bound_i) ? bound_i : ucode;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s_r <= '{dac: DAC_MID, pga: 7'h00, mute: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dac_code_o = s_r.dac;
	assign pga_code_o = s_r.pga;
	assign mute_o     = s_r.mute;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_vol_in_range: assert property ($signed(pga_code_o) <= $signed(VOL_MAX) &&
		$signed(pga_code_o) >= $signed(VOL_MIN)) else $error("gain code out of range");
	a_mute_mid: assert property (!gain_mute_i[BIT_MUTE_N] && !literal_mode_i &&
		!literal_load_i |=> dac_code_o == DAC_MID && mute_o) else $error("mute not silent");
	a_clamp_bound: assert property (smp_valid_i && !literal_mode_i && !literal_load_i
		&& gain_mute_i[BIT_MUTE_N] |=> dac_code_o <= $past(bound_i)) else $error("clamp");
	a_literal_load: assert property (literal_load_i |=>
		dac_code_o == $past(bound_i)) else $error("literal code not loaded");
endmodule

// ### uaoc_host_model.sv
// Purpose: usb host side: isochronous sample pairs, tokens and packet ends
// Assumes: the bench calls the tasks right after a rising clock edge
// Notes:   released data lines show the inverse of the last value, not a stale copy
`timescale 1ns/1ps
module uaoc_host_model (
	input  wire logic        core_clk_i,
	input  wire logic        iso_ready_i,
	input  wire logic        tok_accept_i,
	output logic             iso_valid_o,
	output logic      [15:0] iso_left_o,
	output logic      [15:0] iso_right_o,
	output logic             tok_valid_o,
	output logic      [1:0]  tok_ep_o,
	output logic             tok_in_o,
	output logic      [2:0]  pkt_done_o
);
	initial begin
		iso_valid_o = 1'b0;
		iso_left_o  = 16'h0000;
		iso_right_o = 16'hffff;
		tok_valid_o = 1'b0;
		tok_ep_o    = 2'h0;
		tok_in_o    = 1'b0;
		pkt_done_o  = 3'h0;
	end
	function automatic logic [15:0] sl(input int i);
		return 16'(i * 113);
	endfunction
	function automatic logic [15:0] sr(input int i);
		return 16'hc000 ^ 16'(i * 211);
	endfunction
	// pair held until ready is sampled high; keep chains pairs back to back
	task automatic put(input logic [15:0] l, input logic [15:0] r, input logic keep);
		iso_valid_o <= 1'b1;
		iso_left_o  <= l;
		iso_right_o <= r;
		do @(posedge core_clk_i); while (iso_ready_i !== 1'b1);
		if (!keep) begin
			iso_valid_o <= 1'b0;
			iso_left_o  <= ~l;
			iso_right_o <= ~r;
		end
	endtask
	task automatic one(input logic [15:0] l, input logic [15:0] r);
		@(posedge core_clk_i);
		put(l, r, 1'b0);
	endtask
	// slow leaves an idle cycle between pairs
	task automatic burst(input int n, input logic slow);
		@(posedge core_clk_i);
		for (int i = 0; i < n; i++) begin
			put(sl(i), sr(i), !slow && i != n - 1);
			if (slow)
				@(posedge core_clk_i);
		end
	endtask
	task automatic token(input logic [1:0] ep, input logic is_in, output logic acc);
		@(posedge core_clk_i);
		tok_valid_o <= 1'b1;
		tok_ep_o    <= ep;
		tok_in_o    <= is_in;
		@(posedge core_clk_i);
		acc = tok_accept_i;
		tok_valid_o <= 1'b0;
		tok_ep_o    <= ~ep;
		tok_in_o    <= ~is_in;
	endtask
	task automatic pkt(input int ep);
		@(posedge core_clk_i);
		pkt_done_o <= 3'(1 << ep);
		@(posedge core_clk_i);
		pkt_done_o <= 3'h0;
	endtask
endmodule

// ### uaoc_top_tb.sv
// Purpose: register level tests of the usb audio output control block
// Assumes: two wait cycles per access are not relied on; the bench waits
// Notes:   bank bytes are checked at a few positions only, to keep the run short
`timescale 1ns/1ps
module uaoc_top_tb;
	import uaoc_pkg::*;
	logic        core_clk_i = 1'b0, rst_i = 1'b1;
	logic [11:0] adr = 12'h0;
	logic        rd_q = 1'b0, wr_q = 1'b0;
	logic [31:0] wd = 32'h0, rdata, v;
	logic        wait_o, iso_v, iso_rdy, tok_v, tok_i, tok_acc, acc;
	logic [15:0] iso_l, iso_r, dac_l, dac_r;
	logic [1:0]  tok_e, ep_sel;
	logic [2:0]  pkt, pid1, ep_en = 3'h0;
	logic [7:0]  ep_rdata = 8'ha5, ep_wd;
	logic        restart, dir1, dir2, ep_rd, ep_wr, mute, irq;
	logic [6:0]  pga;
	int          mismatches = 0, checks_done = 0, cycles = 0, n_rst = 0, n_rd = 0, n_wr = 0;
	logic [7:0]  gin[6] = '{8'h8c, 8'h80, 8'he8, 8'hd4, 8'h8d, 8'hd3};
	logic [6:0]  gex[6] = '{7'h0c, 7'h00, 7'h68, 7'h54, 7'h0c, 7'h54};
	int          pos[3] = '{0, 1, 255};
	uaoc_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .iso_valid_i(iso_v), .iso_left_i(iso_l),
		.iso_right_i(iso_r), .iso_ready_o(iso_rdy), .tok_valid_i(tok_v), .tok_ep_i(tok_e),
		.tok_in_i(tok_i), .tok_accept_o(tok_acc), .pkt_done_i(pkt), .pid_data1_o(pid1),
		.data0_restart_o(restart), .ep1_dir_o(dir1), .ep2_dir_o(dir2), .ep_enable_i(ep_en),
		.ep_rdata_i(ep_rdata), .ep_sel_o(ep_sel), .ep_rd_o(ep_rd), .ep_wr_o(ep_wr),
		.ep_wdata_o(ep_wd), .dac_l_code_o(dac_l), .dac_r_code_o(dac_r), .pga_code_o(pga),
		.mute_o(mute), .irq_o(irq));
	uaoc_host_model host (.core_clk_i(core_clk_i), .iso_ready_i(iso_rdy),
		.tok_accept_i(tok_acc), .iso_valid_o(iso_v), .iso_left_o(iso_l),
		.iso_right_o(iso_r), .tok_valid_o(tok_v), .tok_ep_o(tok_e), .tok_in_o(tok_i),
		.pkt_done_o(pkt));
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		n_rst  <= n_rst + int'(restart === 1'b1);
		n_rd   <= n_rd + int'(ep_rd === 1'b1);
		n_wr   <= n_wr + int'(ep_wr === 1'b1);
		// ceiling is well over ten times the expected run of about 1300 cycles
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge core_clk_i);
		adr  <= {idx, 2'b00};
		wr_q <= w;
		rd_q <= !w;
		wd   <= {24'h0, d};
		do @(posedge core_clk_i); while (wait_o !== 1'b0);
		v = rdata;
		wr_q <= 1'b0;
		rd_q <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [9:0] idx);
		bus(1'b0, idx, 8'h00);
	endtask
	task automatic settle();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	function automatic logic [7:0] bb(input logic [15:0] s);
		return {s[15], s[13:7]};
	endfunction
	function automatic logic [15:0] avg(input logic [15:0] l, input logic [15:0] r);
		logic [16:0] s;
		s = {l[15], l} + {r[15], r};
		return s[16:1];
	endfunction
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(IDX_DIR);         chk("dir reset", v, 32'h02);
		rd(IDX_TRIG);        chk("trigger reset", v, 32'h0);
		chk("dac reset", {dac_l, dac_r}, {DAC_MID, DAC_MID});
		chk("mute reset", mute, 1'b1);
		rd(10'h3ff);         chk("unmapped", v, 32'h0);
		wr(IDX_DIR, 8'hfc);  rd(IDX_DIR); chk("dir rw", v, 32'h04);
		chk("dir pins", {dir1, dir2}, 2'b01);
		host.token(2'd1, 1'b1, acc); chk("ep1 in refused", acc, 1'b0);
		host.token(2'd1, 1'b0, acc); chk("ep1 out", acc, 1'b1);
		host.token(2'd2, 1'b1, acc); chk("ep2 in", acc, 1'b1);
		host.token(2'd0, 1'b1, acc); chk("ep0 in", acc, 1'b1);
		#1 chk("irq masked", irq, 1'b0);
		wr(IDX_IRQ_MASK, 8'h02); #1 chk("irq raised", irq, 1'b1);
		wr(IDX_IRQ_STAT, 8'h02); rd(IDX_IRQ_STAT); chk("stat clear", v & 2, 32'h0);
		chk("irq cleared", irq, 1'b0);
		host.pkt(2); #1 chk("pid toggled", pid1, 3'b100);
		wr(IDX_DIR, 8'h05); settle();
		chk("pid restart", pid1, 3'b000);
		chk("restart pulse", n_rst, 1);
		@(posedge core_clk_i) ep_en <= 3'b011;
		rd(IDX_EP2); chk("port off", v, 32'h0);
		#1 chk("no pop", n_rd, 0);
		rd(IDX_EP0); chk("port on", v, 32'ha5);
		#1 chk("pop", n_rd, 1);
		wr(IDX_EP0 + 10'd1, 8'h3c); #1 chk("push", n_wr, 1);
		chk("push port", {ep_sel, ep_wd}, {2'd1, 8'h3c});
		wr(IDX_EP2, 8'h11); #1 chk("no push", n_wr, 1);
		for (int i = 0; i < 6; i++) begin
			wr(IDX_GAIN, gin[i]); settle();
			chk("gain", {mute, pga}, {1'b0, gex[i]});
		end
		wr(IDX_GAIN, 8'h80); wr(IDX_BOUND_LO, 8'h00); wr(IDX_BOUND_HI, 8'h90);
		host.one(16'h7fff, 16'h0100); settle();
		chk("clamp", {dac_l, dac_r}, 32'h90008100);
		wr(IDX_GAIN, 8'h00); settle();
		chk("muted", {mute, dac_l}, {1'b1, DAC_MID});
		wr(IDX_GAIN, 8'h80); wr(IDX_WDT, 8'h50);
		wr(IDX_BOUND_LO, 8'h34); wr(IDX_BOUND_HI, 8'h12);
		wr(IDX_TRIG, 8'hff); rd(IDX_TRIG); chk("trigger", v, 32'h08);
		wr(IDX_TRIG, 8'h00); settle();
		chk("literal", {dac_l, dac_r}, 32'h12341234);
		host.one(16'h0000, 16'h0000); settle();
		chk("literal held", dac_l, 16'h1234);
		wr(IDX_BOUND_LO, 8'h00); wr(IDX_BOUND_HI, 8'h80);
		wr(IDX_TRIG, 8'h08); wr(IDX_TRIG, 8'h00); settle();
		chk("mid load", {dac_l, dac_r}, {DAC_MID, DAC_MID});
		wr(IDX_WDT, 8'h00);
		wr(IDX_BANK_CTL, 8'h05); host.burst(256, 1'b1);
		rd(IDX_BANK_CTL); chk("lr full", v, 32'h06);
		for (int i = 0; i < 3; i++) begin
			rd(IDX_RAM_BASE + 10'(pos[i])); chk("left", v, 32'(bb(host.sl(pos[i]))));
			rd(IDX_RAM_BASE + 10'(256 + pos[i]));
			chk("right", v, 32'(bb(host.sr(pos[i]))));
		end
		wr(IDX_BANK_CTL, 8'h00); rd(IDX_BANK_CTL); chk("full clr", v, 32'h0);
		wr(IDX_BANK_CTL, 8'h01); host.burst(512, 1'b0);
		rd(IDX_BANK_CTL); chk("mix full", v, 32'h02);
		rd(IDX_IRQ_STAT); chk("fill event", v & 1, 32'h1);
		for (int n = 0; n < 512; n += 173) begin
			rd(IDX_RAM_BASE + 10'(n));
			chk("mix", v, 32'(bb(avg(host.sl(n), host.sr(n)))));
		end
		rd(IDX_RAM_BASE + 10'h1ff);
		chk("mix last", v, 32'(bb(avg(host.sl(511), host.sr(511)))));
		test_done();
	end
endmodule
